/* File: bench/nbac_core_model.sv */
// Core model driving the special function register bus
`timescale 1ns/100ps
module nbac_core_model
  import nbac_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic      [7:0] wdata_out,
  output logic            clr_out,
  output logic            svc_out
);
  initial
  begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    {wr_out, rd_out, clr_out, svc_out} = 4'h0;
  end
  // Released lines invert so stale values never look valid
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in) #1;
    wr_out = 1'b0;
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
  endtask
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in) #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in) #1;
    rd_out = 1'b0;
    d = rdata_in;
    addr_out = ~addr_out;
  endtask
  task automatic pulse(input logic c, input logic s);
    @(posedge clk_in) #1;
    clr_out = c;
    svc_out = s;
    @(posedge clk_in) #1;
    clr_out = 1'b0;
    svc_out = 1'b0;
  endtask
endmodule

/* File: bench/nbac_ctrl_tb.sv */
// Self-checking bench for the store access controller
`timescale 1ns/100ps
module nbac_ctrl_tb
  import nbac_pkg::*;
;
  localparam int WC = 10;
  logic       clk;
  logic       rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr;
  logic       rd;
  logic       clr;
  logic       svc;
  logic       done;
  logic       irq;
  logic       busy;
  logic [7:0] mem [MEM_DEPTH];
  int         n_fail;
  int         checked;
  int         cyc;

  nbac_ctrl #(.WRITE_CYCLES_P(WC)) uut (
    .CORE_CLK_IN(clk), .RST_IN(rst), .SFR_ADDR_IN(addr),
    .SFR_WR_IN(wr), .SFR_RD_IN(rd), .SFR_WDATA_IN(wdata),
    .DONE_FLAG_CLR_IN(clr), .IRQ_SERVICED_IN(svc),
    .SFR_RDATA_OUT(rdata), .NVM_DONE_FLAG_OUT(done),
    .MF_IRQ_FLAG_OUT(irq), .NVM_BUSY_OUT(busy));
  nbac_core_model core (
    .clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wdata), .clr_out(clr), .svc_out(svc));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] ctl(input logic wen, wc, ren, rc);
    return {4'h0, wen, wc, ren, rc};
  endfunction
  task automatic poll(input int b);
    logic [7:0] d;
    d = 8'hFF;
    for (int i = 0; i < 40 && d[b] !== 1'b0; i++)
      core.sfr_rd(SFR_IND_PORT, d);
    chk({7'h00, d[b]}, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  initial
  begin
    logic [7:0] d;
    logic [7:0] ix;
    logic [7:0] dv;
    rst = 1'b1;
    void'($urandom(81));
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    core.sfr_rd(SFR_IDX, d);
    chk(d, RST_BYTE);
    core.sfr_rd(SFR_VAL, d);
    chk(d, RST_BYTE);
    core.sfr_wr(SFR_IND_PTR, CTRL_LOC);
    core.sfr_wr(SFR_IND_PORT, 8'h0A);
    core.sfr_wr(SFR_BANK_SEL, 8'h01);
    core.sfr_rd(SFR_IND_PORT, d);
    chk(d, ctl(0, 0, 0, 0));
    core.sfr_wr(SFR_IND_PORT, 8'hF4);
    core.sfr_rd(SFR_IND_PORT, d);
    chk(d, ctl(0, 0, 0, 0));
    core.sfr_wr(SFR_IND_PORT, 8'h05);
    core.sfr_rd(SFR_IND_PORT, d);
    chk(d, ctl(0, 0, 0, 0));
    core.sfr_wr(SFR_IDX, 8'hFF);
    core.sfr_rd(SFR_IDX, d);
    chk(d, 8'h3F);
    core.sfr_rd(8'h55, d);
    chk(d, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 4; k++)
    begin
      ix = (k == 0) ? 8'h00 : (k == 1) ? 8'h3F : 8'($urandom % 64);
      dv = 8'($urandom);
      mem[ix[5:0]] = dv;
      core.sfr_wr(SFR_IDX, ix);
      core.sfr_wr(SFR_VAL, dv);
      core.sfr_wr(SFR_IND_PORT, 8'h08);
      core.sfr_wr(SFR_IND_PORT, 8'h0C);
      core.sfr_wr(SFR_IND_PORT, 8'h08);
      core.sfr_rd(SFR_IND_PORT, d);
      chk(d, ctl(1, 1, 0, 0));
      chk({7'h00, busy}, 8'h01);
      poll(CTL_WR);
      core.sfr_wr(SFR_IND_PORT, 8'h00);
      chk({6'h00, done, irq}, 8'h03);
      core.pulse(1'b0, 1'b1);
      chk({6'h00, done, irq}, 8'h02);
      core.pulse(1'b1, 1'b0);
      chk({6'h00, done, irq}, 8'h00);
      core.sfr_wr(SFR_VAL, ~dv);
      core.sfr_wr(SFR_IND_PORT, 8'h02);
      core.sfr_wr(SFR_IND_PORT, 8'h03);
      poll(CTL_RD);
      core.sfr_wr(SFR_IDX, ix ^ 8'h01);
      core.sfr_rd(SFR_VAL, d);
      chk(d, mem[ix[5:0]]);
      $display("test transfer %0d done", k);
    end
    report_and_stop();
  end
endmodule

/* File: rtl/nbac_ctrl.sv */
// Byte-wide non-volatile store access controller
// Operation
// - Store holds 64 bytes; each operation moves one byte at the index.
// - Index register keeps six bits; upper two read as zero.
// - Index and value registers are directly addressed whatever the bank select.
// - Control register is at 40H of bank 1, reached only indirectly.
// - Control bit 3 permits writes; when clear no write starts.
// - Setting bit 2 starts a write only if permit already set.
// - Hardware clears write command bit when the write cycle ends.
// - Write duration comes from an internal timer, many cycles long.
// - Write completion shows as command bit clear and as an event.
// - Control bit 1 permits reads; when clear no read starts.
// - Setting bit 0 starts a read only if read permit already set.
// - Read end clears read command bit; byte then in value register.
// - Value register holds fetched byte until next read or write.
// - Reset clears all control bits, index and value registers.
// - Write end sets done flag and shared flag; service clears shared.
// - Bank select bit 0 picks bank for indirect access; resets to 0.
`timescale 1ns/100ps
module nbac_ctrl
  import nbac_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
)
(
  input  wire logic       CORE_CLK_IN,
  input  wire logic       RST_IN,
  input  wire logic [7:0] SFR_ADDR_IN,
  input  wire logic       SFR_WR_IN,
  input  wire logic       SFR_RD_IN,
  input  wire logic [7:0] SFR_WDATA_IN,
  input  wire logic       DONE_FLAG_CLR_IN,
  input  wire logic       IRQ_SERVICED_IN,
  output logic      [7:0] SFR_RDATA_OUT,
  output logic            NVM_DONE_FLAG_OUT,
  output logic            MF_IRQ_FLAG_OUT,
  output logic            NVM_BUSY_OUT
);

  logic [7:0]       mem [MEM_DEPTH];
  logic [IDX_W-1:0] nvm_byte_index_q;
  logic [7:0]       nvm_byte_value_q;
  logic [7:0]       indirect_pointer_one_q;
  logic             bank_select_q;
  logic             program_permit_q;
  logic             fetch_permit_q;
  logic             wr_cmd_q;
  logic             rd_cmd_q;
  logic             nvm_done_flag_q;
  logic             mf_flag_q;
  logic [IDX_W-1:0] lat_idx_q;
  logic [7:0]       lat_val_q;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0]       rdata_q;
  nbac_state_e      state_q;
  nbac_state_e      state_d;

  // Indirect access reaches the control register only in bank 1
  wire sel_ctrl = bank_select_q
                  & (indirect_pointer_one_q == CTRL_LOC);
  wire wr_ctrl  = SFR_WR_IN & (SFR_ADDR_IN == SFR_IND_PORT) & sel_ctrl;
  wire wr_idx   = SFR_WR_IN & (SFR_ADDR_IN == SFR_IDX);
  wire wr_val   = SFR_WR_IN & (SFR_ADDR_IN == SFR_VAL);
  wire wr_ptr   = SFR_WR_IN & (SFR_ADDR_IN == SFR_IND_PTR);
  wire wr_bank  = SFR_WR_IN & (SFR_ADDR_IN == SFR_BANK_SEL);
  wire idle     = (state_q == ST_IDLE);
  // Permit is the value held before this write
  wire start_wr = idle & wr_ctrl & SFR_WDATA_IN[CTL_WR]
                  & program_permit_q;
  wire start_rd = idle & wr_ctrl & SFR_WDATA_IN[CTL_RD]
                  & fetch_permit_q & ~start_wr;
  wire cnt_end  = (cnt_q == '0);
  wire wr_done  = (state_q == ST_WRITE) & cnt_end;
  wire rd_done  = (state_q == ST_READ) & cnt_end;
  wire [7:0] ctrl_view = {4'h0, program_permit_q, wr_cmd_q,
                          fetch_permit_q, rd_cmd_q};
  wire [7:0] rdata_d =
    (SFR_ADDR_IN == SFR_IDX)  ? {2'b00, nvm_byte_index_q} :
    (SFR_ADDR_IN == SFR_VAL)  ? nvm_byte_value_q :
    (SFR_ADDR_IN == SFR_IND_PTR)  ? indirect_pointer_one_q :
    (SFR_ADDR_IN == SFR_BANK_SEL) ? {7'h00, bank_select_q} :
    ((SFR_ADDR_IN == SFR_IND_PORT) & sel_ctrl) ? ctrl_view : 8'h00;
  wire [CNT_W-1:0] wr_load = CNT_W'(WRITE_CYCLES_P - 1);
  wire [CNT_W-1:0] rd_load = CNT_W'(READ_CYCLES - 1);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (start_wr)
          state_d = ST_WRITE;
        else if (start_rd)
          state_d = ST_READ;
      end
      ST_READ:
      begin
        if (cnt_end)
          state_d = ST_IDLE;
      end
      ST_WRITE:
      begin
        if (cnt_end)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      state_q                <= ST_IDLE;
      cnt_q                  <= '0;
      lat_idx_q              <= '0;
      lat_val_q              <= RST_BYTE;
    end
    else
    begin
      state_q <= state_d;
      if (start_wr)
        cnt_q <= wr_load;
      else if (start_rd)
        cnt_q <= rd_load;
      else if (!idle && !cnt_end)
        cnt_q <= cnt_q - 1'b1;
      if (start_wr || start_rd)
      begin
        lat_idx_q <= nvm_byte_index_q;
        lat_val_q <= nvm_byte_value_q;
      end
    end
  end

  // Control and data registers, all cleared at reset
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      nvm_byte_index_q       <= '0;
      nvm_byte_value_q       <= RST_BYTE;
      indirect_pointer_one_q <= RST_BYTE;
      bank_select_q          <= RST_BIT;
      program_permit_q       <= RST_BIT;
      fetch_permit_q         <= RST_BIT;
      wr_cmd_q               <= RST_BIT;
      rd_cmd_q               <= RST_BIT;
      rdata_q                <= RST_BYTE;
    end
    else
    begin
      if (wr_idx)
        nvm_byte_index_q <= SFR_WDATA_IN[IDX_W-1:0];
      if (rd_done)
        nvm_byte_value_q <= mem[lat_idx_q];
      else if (wr_val)
        nvm_byte_value_q <= SFR_WDATA_IN;
      if (wr_ptr)
        indirect_pointer_one_q <= SFR_WDATA_IN;
      if (wr_bank)
        bank_select_q <= SFR_WDATA_IN[0];
      if (wr_ctrl)
      begin
        program_permit_q <= SFR_WDATA_IN[CTL_PROG_PERMIT];
        fetch_permit_q   <= SFR_WDATA_IN[CTL_FETCH_PERMIT];
      end
      wr_cmd_q <= start_wr | (wr_cmd_q & ~wr_done);
      rd_cmd_q <= start_rd | (rd_cmd_q & ~rd_done);
      if (SFR_RD_IN)
        rdata_q <= rdata_d;
    end
  end

  // Completion flags; a new completion beats a same-cycle clear
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      nvm_done_flag_q <= RST_BIT;
      mf_flag_q       <= RST_BIT;
    end
    else
    begin
      nvm_done_flag_q <= wr_done
                         | (nvm_done_flag_q & ~DONE_FLAG_CLR_IN);
      mf_flag_q       <= wr_done
                         | (mf_flag_q & ~IRQ_SERVICED_IN);
    end
  end

  // Store array, non-volatile so not reset
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (wr_done)
      mem[lat_idx_q] <= lat_val_q;
  end

  assign SFR_RDATA_OUT     = rdata_q;
  assign NVM_DONE_FLAG_OUT = nvm_done_flag_q;
  assign MF_IRQ_FLAG_OUT   = mf_flag_q;
  assign NVM_BUSY_OUT      = ~idle;

  property p_wr_permit;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      $rose(wr_cmd_q) |-> $past(program_permit_q);
  endproperty
  a_wr_permit: assert property (p_wr_permit)
    else $error("write started without permit");

  property p_rd_permit;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      $rose(rd_cmd_q) |-> $past(fetch_permit_q);
  endproperty
  a_rd_permit: assert property (p_rd_permit)
    else $error("read started without permit");

  property p_wr_start;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (idle && wr_ctrl && SFR_WDATA_IN[CTL_WR] && program_permit_q)
        |=> wr_cmd_q && state_q == ST_WRITE;
  endproperty
  a_wr_start: assert property (p_wr_start)
    else $error("permitted write did not start");

  property p_wr_clear;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      wr_done |=> !wr_cmd_q && idle;
  endproperty
  a_wr_clear: assert property (p_wr_clear)
    else $error("write command not cleared at end");

  property p_done_event;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      $fell(wr_cmd_q) |-> nvm_done_flag_q && mf_flag_q;
  endproperty
  a_done_event: assert property (p_done_event)
    else $error("write end raised no flags");

  property p_rd_data;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      rd_done |=> !rd_cmd_q && nvm_byte_value_q == $past(mem[lat_idx_q]);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("read end left wrong value");

  property p_rd_len;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      $rose(rd_cmd_q) |-> rd_cmd_q ##1 rd_cmd_q ##1 !rd_cmd_q;
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read cycle length wrong");

  property p_value_hold;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (!rd_done && !wr_val) |=> $stable(nvm_byte_value_q);
  endproperty
  a_value_hold: assert property (p_value_hold)
    else $error("value register changed without cause");

  property p_no_overlap;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      !(wr_cmd_q && rd_cmd_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("read and write active together");

  property p_ctrl_upper;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (SFR_RD_IN && SFR_ADDR_IN == SFR_IND_PORT && sel_ctrl)
        |=> SFR_RDATA_OUT[7:4] == 4'h0;
  endproperty
  a_ctrl_upper: assert property (p_ctrl_upper)
    else $error("control upper bits not zero");

  property p_idx_upper;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (SFR_RD_IN && SFR_ADDR_IN == SFR_IDX)
        |=> SFR_RDATA_OUT[7:6] == 2'b00;
  endproperty
  a_idx_upper: assert property (p_idx_upper)
    else $error("index upper bits not zero");

endmodule

/* File: shared/nbac_pkg.sv */
// Constants for the byte-wide non-volatile store access controller
package nbac_pkg;
  // Special function register locations seen by the core
  localparam logic [7:0] SFR_IND_PORT = 8'h02;
  localparam logic [7:0] SFR_IND_PTR  = 8'h03;
  localparam logic [7:0] SFR_BANK_SEL = 8'h04;
  localparam logic [7:0] SFR_IDX  = 8'h2A;
  localparam logic [7:0] SFR_VAL  = 8'h2B;
  // Control register location in bank 1
  localparam logic [7:0] CTRL_LOC = 8'h40;
  // Control register bit positions
  localparam int CTL_PROG_PERMIT  = 3;
  localparam int CTL_WR           = 2;
  localparam int CTL_FETCH_PERMIT = 1;
  localparam int CTL_RD           = 0;
  // Store geometry
  localparam int IDX_W     = 6;
  localparam int MEM_DEPTH = 64;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic       RST_BIT  = 1'b0;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int WRITE_TIME_NS = 2000000;
  localparam int READ_TIME_NS  = 200;
  localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int READ_CYCLES   =
    (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } nbac_state_e;
endpackage
